// ===== design/exposure_timer.sv
// exposure timer counting lines or prescaled clock cycles
`timescale 1ns/1ps
module exposure_timer (
	input  wire logic  i_mclk,
	input  wire logic  i_nrst,
	seq_link_if.timer  link
);
	logic [15:0] count;
	logic [15:0] pre;
	logic        running;
	logic        step;

	// in line mode one step per row overhead, else one per 2**prescale cycles
	always_comb begin
		if (link.in_cycles) begin
			step = (pre == 16'((32'd1 << link.prescale) - 32'd1));
		end else begin
			step = link.tick;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst || link.start || !running || step) begin
			pre <= 16'h0000;
		end else begin
			pre <= pre + 16'h0001;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			count   <= 16'h0000;
			running <= 1'b0;
		end else if (link.start) begin
			count   <= link.tick_limit;
			running <= 1'b1;
		end else if (running && step) begin
			if (count <= 16'h0001) begin
				running <= 1'b0;
				count   <= 16'h0000;
			end else begin
				count <= count - 16'h0001;
			end
		end
	end

	assign link.expired = running && step && (count <= 16'h0001);
endmodule : exposure_timer

// ===== design/seq_link_if.sv
// interface carrying readout slot events from the sequencer to the stream encoder
`timescale 1ns/1ps
interface seq_link_if;
	logic                     slot_valid;
	seq_pkg::slot_kind_type   slot_kind;
	logic [15:0]              slot_index;
	logic                     tick;
	logic [15:0]              tick_limit;
	logic                     expired;
	logic                     start;
	logic [3:0]               prescale;
	logic                     in_cycles;

	modport sequencer (output slot_valid, output slot_kind, output slot_index,
		output start, output tick_limit, output prescale, output in_cycles,
		input expired, input tick);
	modport encoder (input slot_valid, input slot_kind, input slot_index);
	modport timer (input start, input tick_limit, input prescale, input in_cycles,
		input tick, output expired);
endinterface : seq_link_if

// ===== design/seq_pkg.sv
// package of constants and types for the shutter readout sequencer
package seq_pkg;
	// register byte offsets
	localparam logic [7:0] SEQUENCER_MODE_OFFSET   = 8'h00;
	localparam logic [7:0] EXPOSURE_CONFIG_OFFSET  = 8'h04;
	localparam logic [7:0] CYCLE_PRESCALE_OFFSET   = 8'h08;
	localparam logic [7:0] RESET_LENGTH_OFFSET     = 8'h0C;
	localparam logic [7:0] INTEGRATION_OFFSET      = 8'h10;
	localparam logic [7:0] ROW_OVERHEAD_OFFSET     = 8'h14;
	localparam logic [7:0] FRAME_OVERHEAD_OFFSET   = 8'h18;
	localparam logic [7:0] LINE_COUNT_OFFSET       = 8'h1C;
	localparam logic [7:0] KERNEL_COUNT_OFFSET     = 8'h20;
	localparam logic [7:0] NDR_STEPS_OFFSET        = 8'h24;
	localparam logic [7:0] STATUS_OFFSET           = 8'h28;
	// field positions
	localparam int MODE_ENABLE_BIT    = 0;
	localparam int MODE_PIN_TIMED_BIT = 1;
	localparam int MODE_TRIGGERED_BIT = 2;
	localparam int EXP_CYCLES_BIT     = 6;
	localparam int EXP_SYNC_ROT_BIT   = 7;
	// reset values
	localparam logic [7:0]  SEQUENCER_MODE_RESET = 8'h00;
	localparam logic [7:0]  EXPOSURE_RESET       = 8'h00;
	localparam logic [3:0]  PRESCALE_RESET       = 4'h0;
	localparam logic [15:0] RESET_LENGTH_RESET   = 16'h0010;
	localparam logic [15:0] INTEGRATION_RESET    = 16'h0400;
	localparam logic [15:0] ROT_RESET            = 16'h0009;
	localparam logic [15:0] FOT_RESET            = 16'h013B;
	localparam logic [15:0] LINE_COUNT_RESET     = 16'h0400;
	localparam logic [7:0]  KERNEL_COUNT_RESET   = 8'h36;
	localparam logic [7:0]  NDR_STEPS_RESET      = 8'h01;
	// sync channel codes
	localparam logic [9:0] FRAME_BEGIN_CODE        = 10'h059;
	localparam logic [9:0] LINE_BEGIN_CODE         = 10'h056;
	localparam logic [9:0] FRAME_FINISH_CODE       = 10'h05A;
	localparam logic [9:0] LINE_FINISH_CODE        = 10'h055;
	localparam logic [9:0] GREY_BLACK_COLUMN_CODE  = 10'h0A9;
	localparam logic [9:0] CHECKSUM_CODE           = 10'h0A6;
	localparam logic [9:0] FIXED_PATTERN_VALUES_CODE = 10'h13C;
	localparam logic [9:0] NORMAL_DATA_CODE        = 10'h193;
	localparam logic [9:0] IDLE_CODE               = 10'h000;
	localparam int PIXELS_PER_KERNEL = 24;
	localparam int DATA_CHANNELS     = 12;
	localparam int EXTRA_COLUMNS     = 16;

	typedef enum logic [2:0] {
		RD_IDLE  = 3'b000,
		RD_FOT   = 3'b001,
		RD_ROT   = 3'b010,
		RD_DATA  = 3'b011,
		RD_CRC   = 3'b100,
		RD_END   = 3'b101
	} readout_state_type;

	typedef enum logic [1:0] {
		EX_RESET = 2'b00,
		EX_HOLD  = 2'b01,
		EX_INTEG = 2'b10
	} expose_state_type;

	typedef enum logic [3:0] {
		SLOT_NONE  = 4'h0,
		SLOT_FBEG  = 4'h1,
		SLOT_LBEG  = 4'h2,
		SLOT_FFIN  = 4'h3,
		SLOT_LFIN  = 4'h4,
		SLOT_GBC   = 4'h5,
		SLOT_CRC   = 4'h6,
		SLOT_FPN   = 4'h7,
		SLOT_DATA  = 4'h8
	} slot_kind_type;
endpackage : seq_pkg

// ===== design/shutter_sequencer_sync.sv
// shutter readout sequencer with AXI4-Lite register file and sync channel output
//
// Overview of operation
// - pipelined mode integrates next frame while the previous one is read out
// - each frame starts with frame overhead, each line with row overhead
// - exposure config bit 6 picks line or cycle counting for exposure timers
// - in line counting, integration outputs change only during row overhead or while readout is idle
// - cycle counting scales counts by two to the prescale, acting at expiry
// - update-sync bit 7 delays integration updates to the next row overhead
// - exposure timers use lines or cycles; overhead timers always count cycles
// - pipelined pin-timed ignores timers; pin high releases reset, low samples
// - triggered mode reads one image per trigger, array held in reset till then
// - triggered sequencer-timed starts on rising pin edge, timer sets duration
// - timer expiry starts frame overhead and readout; next frame needs new edge
// - triggered pin-timed: rise starts integration, fall starts frame overhead
// - step count sets samples per reset; one means normal operation
// - pin-timed multi-sample keeps pin protocol, suppresses internal resets
// - a dummy reference line is read before the real pixel lines
// - pixels read in 24-pixel kernels; last slot adds 16 extra columns, none added here: its second half is coded grey/black
// - twelve data channels fed by 24 converters plus one sync channel
// - sync codes for frame and line begin and finish as given
// - sync codes for grey/black, checksum, stored pattern and data words; no slot here ever sends the checksum code
// - sequencer mode bit 1 selects sequencer-timed or pin-timed integration
`timescale 1ns/1ps
module shutter_sequencer_sync #(
	parameter int LINE_WIDTH = 16
) (
	input  wire logic                     i_mclk,
	input  wire logic                     i_nrst,
	input  wire logic [7:0]               i_awaddr,
	input  wire logic                     i_awvalid,
	output logic                          o_awready,
	input  wire logic [31:0]              i_wdata,
	input  wire logic [3:0]               i_wstrb,
	input  wire logic                     i_wvalid,
	output logic                          o_wready,
	output logic [1:0]                    o_bresp,
	output logic                          o_bvalid,
	input  wire logic                     i_bready,
	input  wire logic [7:0]               i_araddr,
	input  wire logic                     i_arvalid,
	output logic                          o_arready,
	output logic [31:0]                   o_rdata,
	output logic [1:0]                    o_rresp,
	output logic                          o_rvalid,
	input  wire logic                     i_rready,
	input  wire logic                     i_first_integration_input,
	input  wire logic [9:0]               i_adc_even [seq_pkg::DATA_CHANNELS],
	input  wire logic [9:0]               i_adc_odd  [seq_pkg::DATA_CHANNELS],
	output logic                          o_pixel_reset,
	output logic                          o_pixel_sample,
	output logic                          o_integrating,
	output logic [9:0]                    o_data [seq_pkg::DATA_CHANNELS],
	output logic [9:0]                    o_sync_code
);
	seq_link_if link ();

	logic [7:0]  sequencer_mode_reg;
	logic [7:0]  exposure_config_reg;
	logic [3:0]  cycle_prescale_reg;
	logic [15:0] reset_length_reg;
	logic [15:0] integration_reg;
	logic [15:0] row_overhead_reg;
	logic [15:0] frame_overhead_reg;
	logic [15:0] line_count_reg;
	logic [7:0]  kernel_count_reg;
	logic [7:0]  nondestructive_step_count;

	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	seq_pkg::readout_state_type rd_state;
	seq_pkg::expose_state_type  ex_state;
	logic [15:0] rd_count;
	logic [15:0] line_index;
	logic [7:0]  kernel_index;
	logic        half;
	logic        pin_prev;
	logic        frame_request;
	logic        pending_reset;
	logic        pending_sample;
	logic [7:0]  ndr_index;
	logic [15:0] frame_total;

	logic        enabled;
	logic        pin_timed;
	logic        triggered;
	logic        sync_to_rot;
	logic        in_rot;
	logic        pin_rise;
	logic        pin_fall;
	logic        last_slot;

	assign enabled     = sequencer_mode_reg[seq_pkg::MODE_ENABLE_BIT];
	assign pin_timed   = sequencer_mode_reg[seq_pkg::MODE_PIN_TIMED_BIT];
	assign triggered   = sequencer_mode_reg[seq_pkg::MODE_TRIGGERED_BIT];
	assign sync_to_rot = exposure_config_reg[seq_pkg::EXP_SYNC_ROT_BIT];
	assign in_rot      = (rd_state == seq_pkg::RD_ROT);
	assign pin_rise    = i_first_integration_input && !pin_prev;
	assign pin_fall    = !i_first_integration_input && pin_prev;
	assign last_slot   = (kernel_index == kernel_count_reg - 8'h01);

	// AXI4-Lite write path: address and data accepted independently
	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready  = !w_held && !o_bvalid;
	assign o_bresp   = 2'b00;
	assign o_rresp   = 2'b00;
	assign o_arready = !o_rvalid;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			o_bvalid <= 1'b0;
		end else begin
			if (o_awready && i_awvalid) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (o_wready && i_wvalid) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				o_bvalid <= 1'b1;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// register store; only the byte lane 0 strobe gates the write, unmapped writes are dropped with OKAY
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			sequencer_mode_reg        <= seq_pkg::SEQUENCER_MODE_RESET;
			exposure_config_reg       <= seq_pkg::EXPOSURE_RESET;
			cycle_prescale_reg        <= seq_pkg::PRESCALE_RESET;
			reset_length_reg          <= seq_pkg::RESET_LENGTH_RESET;
			integration_reg           <= seq_pkg::INTEGRATION_RESET;
			row_overhead_reg          <= seq_pkg::ROT_RESET;
			frame_overhead_reg        <= seq_pkg::FOT_RESET;
			line_count_reg            <= seq_pkg::LINE_COUNT_RESET;
			kernel_count_reg          <= seq_pkg::KERNEL_COUNT_RESET;
			nondestructive_step_count <= seq_pkg::NDR_STEPS_RESET;
		end else if (aw_held && w_held && w_strb[0]) begin
			case (aw_addr)
				seq_pkg::SEQUENCER_MODE_OFFSET:  sequencer_mode_reg  <= w_data[7:0];
				seq_pkg::EXPOSURE_CONFIG_OFFSET: exposure_config_reg <= w_data[7:0];
				seq_pkg::CYCLE_PRESCALE_OFFSET:  cycle_prescale_reg  <= w_data[3:0];
				seq_pkg::RESET_LENGTH_OFFSET:    reset_length_reg    <= w_data[15:0];
				seq_pkg::INTEGRATION_OFFSET:     integration_reg     <= w_data[15:0];
				seq_pkg::ROW_OVERHEAD_OFFSET:    row_overhead_reg    <= w_data[15:0];
				seq_pkg::FRAME_OVERHEAD_OFFSET:  frame_overhead_reg  <= w_data[15:0];
				seq_pkg::LINE_COUNT_OFFSET:      line_count_reg      <= w_data[15:0];
				seq_pkg::KERNEL_COUNT_OFFSET:    kernel_count_reg    <= w_data[7:0];
				seq_pkg::NDR_STEPS_OFFSET:       nondestructive_step_count <= w_data[7:0];
				default: begin
				end
			endcase
		end
	end

	// read path, one cycle latency, unmapped reads return zero with OKAY
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
		end else if (o_arready && i_arvalid) begin
			o_rvalid <= 1'b1;
			case (i_araddr)
				seq_pkg::SEQUENCER_MODE_OFFSET:  o_rdata <= {24'h0, sequencer_mode_reg};
				seq_pkg::EXPOSURE_CONFIG_OFFSET: o_rdata <= {24'h0, exposure_config_reg};
				seq_pkg::CYCLE_PRESCALE_OFFSET:  o_rdata <= {28'h0, cycle_prescale_reg};
				seq_pkg::RESET_LENGTH_OFFSET:    o_rdata <= {16'h0, reset_length_reg};
				seq_pkg::INTEGRATION_OFFSET:     o_rdata <= {16'h0, integration_reg};
				seq_pkg::ROW_OVERHEAD_OFFSET:    o_rdata <= {16'h0, row_overhead_reg};
				seq_pkg::FRAME_OVERHEAD_OFFSET:  o_rdata <= {16'h0, frame_overhead_reg};
				seq_pkg::LINE_COUNT_OFFSET:      o_rdata <= {16'h0, line_count_reg};
				seq_pkg::KERNEL_COUNT_OFFSET:    o_rdata <= {24'h0, kernel_count_reg};
				seq_pkg::NDR_STEPS_OFFSET:       o_rdata <= {24'h0, nondestructive_step_count};
				seq_pkg::STATUS_OFFSET:          o_rdata <= {line_index, 5'h00,
					rd_state, 6'h00, ex_state};
				default:                         o_rdata <= 32'h0000_0000;
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= i_first_integration_input;
		end
	end

	// exposure timer drive: reset phase, then integration phase, in lines or cycles
	assign link.in_cycles = exposure_config_reg[seq_pkg::EXP_CYCLES_BIT];
	assign link.prescale  = cycle_prescale_reg;
	assign link.tick      = in_rot && (rd_count == 16'h0000);
	assign link.start     = !pin_timed && enabled && (
		(ex_state == seq_pkg::EX_RESET && !triggered && !frame_request) ||
		(ex_state == seq_pkg::EX_RESET && triggered && pin_rise) ||
		(ex_state == seq_pkg::EX_HOLD && link.expired) ||
		(ex_state == seq_pkg::EX_INTEG && link.expired &&
			ndr_index + 8'h01 < nondestructive_step_count));
	assign link.tick_limit = (ex_state == seq_pkg::EX_RESET && !triggered) ?
		reset_length_reg : integration_reg;

	// exposure state machine; pending flags let updates wait for row overhead
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			ex_state       <= seq_pkg::EX_RESET;
			pending_reset  <= 1'b0;
			pending_sample <= 1'b0;
			frame_request  <= 1'b0;
			ndr_index      <= 8'h00;
		end else begin
			// lines mode and the sync bit both defer updates to row overhead;
			// clears come first so an event in the same cycle sets the flag again
			if (pending_reset && (in_rot || !(sync_to_rot || !link.in_cycles) ||
				rd_state == seq_pkg::RD_IDLE)) begin
				pending_reset <= 1'b0;
			end
			if (pending_sample && (in_rot || !(sync_to_rot || !link.in_cycles) ||
				rd_state == seq_pkg::RD_IDLE)) begin
				pending_sample <= 1'b0;
			end
			if (rd_state == seq_pkg::RD_FOT) begin
				frame_request <= 1'b0;
			end
			case (ex_state)
				seq_pkg::EX_RESET: begin
					if (!enabled) begin
						ex_state <= seq_pkg::EX_RESET;
					end else if (pin_timed && pin_rise) begin
						ex_state      <= seq_pkg::EX_INTEG;
						pending_reset <= 1'b1;
					end else if (!pin_timed && triggered && pin_rise) begin
						ex_state      <= seq_pkg::EX_INTEG;
						pending_reset <= 1'b1;
					end else if (link.start) begin
						ex_state <= seq_pkg::EX_HOLD;
					end
				end
				seq_pkg::EX_HOLD: begin
					if (link.expired) begin
						ex_state      <= seq_pkg::EX_INTEG;
						pending_reset <= 1'b1;
					end
				end
				seq_pkg::EX_INTEG: begin
					if ((pin_timed && pin_fall) || (!pin_timed && link.expired)) begin
						pending_sample <= 1'b1;
						frame_request  <= 1'b1;
						if (ndr_index + 8'h01 < nondestructive_step_count) begin
							ndr_index <= ndr_index + 8'h01;
							ex_state  <= pin_timed ? seq_pkg::EX_RESET : seq_pkg::EX_INTEG;
						end else begin
							ndr_index <= 8'h00;
							ex_state  <= seq_pkg::EX_RESET;
						end
					end
				end
				default: ex_state <= seq_pkg::EX_RESET;
			endcase
		end
	end

	// pixel control outputs; array stays in reset until integration starts
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_pixel_reset  <= 1'b1;
			o_integrating  <= 1'b0;
			o_pixel_sample <= 1'b0;
		end else begin
			if (pending_reset && !pending_sample && (in_rot || rd_state == seq_pkg::RD_IDLE ||
				!(sync_to_rot || !link.in_cycles))) begin
				o_pixel_reset <= 1'b0;
				o_integrating <= 1'b1;
			end
			o_pixel_sample <= 1'b0;
			if (pending_sample && (in_rot || rd_state == seq_pkg::RD_IDLE ||
				!(sync_to_rot || !link.in_cycles))) begin
				o_pixel_sample <= 1'b1;
				o_integrating  <= 1'b0;
				// multi-sample keeps the array out of reset between samples
				o_pixel_reset  <= (ndr_index == 8'h00);
			end
		end
	end

	// readout: frame overhead, dummy line, then lines of row overhead and kernels
	assign frame_total = line_count_reg + 16'h0001;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			rd_state     <= seq_pkg::RD_IDLE;
			rd_count     <= 16'h0000;
			line_index   <= 16'h0000;
			kernel_index <= 8'h00;
			half         <= 1'b0;
		end else begin
			case (rd_state)
				seq_pkg::RD_IDLE: begin
					if (o_pixel_sample) begin
						rd_state <= seq_pkg::RD_FOT;
						rd_count <= frame_overhead_reg;
					end
				end
				seq_pkg::RD_FOT: begin
					if (rd_count == 16'h0000) begin
						rd_state   <= seq_pkg::RD_ROT;
						rd_count   <= row_overhead_reg;
						line_index <= 16'h0000;
					end else begin
						rd_count <= rd_count - 16'h0001;
					end
				end
				seq_pkg::RD_ROT: begin
					if (rd_count == 16'h0000) begin
						rd_state     <= seq_pkg::RD_DATA;
						kernel_index <= 8'h00;
						half         <= 1'b0;
					end else begin
						rd_count <= rd_count - 16'h0001;
					end
				end
				seq_pkg::RD_DATA: begin
					half <= !half;
					if (half) begin
						if (last_slot) begin
							rd_state <= seq_pkg::RD_CRC;
						end else begin
							kernel_index <= kernel_index + 8'h01;
						end
					end
				end
				seq_pkg::RD_CRC: begin
					if (line_index + 16'h0001 == frame_total) begin
						rd_state <= seq_pkg::RD_END;
					end else begin
						rd_state   <= seq_pkg::RD_ROT;
						rd_count   <= row_overhead_reg;
						line_index <= line_index + 16'h0001;
					end
				end
				seq_pkg::RD_END: rd_state <= seq_pkg::RD_IDLE;
				default:         rd_state <= seq_pkg::RD_IDLE;
			endcase
		end
	end

	// slot kind presented with the data word of the same cycle
	always_comb begin
		link.slot_valid = 1'b1;
		link.slot_index = {8'h00, kernel_index};
		case (rd_state)
			seq_pkg::RD_DATA: begin
				if (line_index == 16'h0000) begin
					link.slot_kind = seq_pkg::SLOT_FPN;
				end else if (last_slot && half) begin
					link.slot_kind = seq_pkg::SLOT_GBC;
				end else if (kernel_index == 8'h00 && !half) begin
					link.slot_kind = (line_index == 16'h0001) ? seq_pkg::SLOT_FBEG :
						seq_pkg::SLOT_LBEG;
				end else begin
					link.slot_kind = seq_pkg::SLOT_DATA;
				end
			end
			seq_pkg::RD_CRC: begin
				link.slot_kind = (line_index + 16'h0001 == frame_total) ?
					seq_pkg::SLOT_FFIN : seq_pkg::SLOT_LFIN;
			end
			default: begin
				link.slot_valid = 1'b0;
				link.slot_kind  = seq_pkg::SLOT_NONE;
			end
		endcase
	end

	// data words registered in the same cycle as the sync code
	always_ff @(posedge i_mclk) begin
		for (int ch = 0; ch < seq_pkg::DATA_CHANNELS; ch++) begin
			if (!i_nrst || rd_state != seq_pkg::RD_DATA) begin
				o_data[ch] <= 10'h000;
			end else begin
				o_data[ch] <= half ? i_adc_odd[ch] : i_adc_even[ch];
			end
		end
	end

	exposure_timer u_timer (
		.i_mclk (i_mclk),
		.i_nrst (i_nrst),
		.link   (link.timer)
	);

	sync_encoder u_sync (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.link        (link.encoder),
		.o_sync_code (o_sync_code)
	);
endmodule : shutter_sequencer_sync

// ===== design/sync_encoder.sv
// maps readout slot kinds to sync channel codes, registered in step with the data words
`timescale 1ns/1ps
module sync_encoder (
	input  wire logic    i_mclk,
	input  wire logic    i_nrst,
	seq_link_if.encoder  link,
	output logic [9:0]   o_sync_code
);
	function automatic logic [9:0] code_of(input seq_pkg::slot_kind_type k);
		case (k)
			seq_pkg::SLOT_FBEG: code_of = seq_pkg::FRAME_BEGIN_CODE;
			seq_pkg::SLOT_LBEG: code_of = seq_pkg::LINE_BEGIN_CODE;
			seq_pkg::SLOT_FFIN: code_of = seq_pkg::FRAME_FINISH_CODE;
			seq_pkg::SLOT_LFIN: code_of = seq_pkg::LINE_FINISH_CODE;
			seq_pkg::SLOT_GBC:  code_of = seq_pkg::GREY_BLACK_COLUMN_CODE;
			seq_pkg::SLOT_CRC:  code_of = seq_pkg::CHECKSUM_CODE;
			seq_pkg::SLOT_FPN:  code_of = seq_pkg::FIXED_PATTERN_VALUES_CODE;
			seq_pkg::SLOT_DATA: code_of = seq_pkg::NORMAL_DATA_CODE;
			default:            code_of = seq_pkg::IDLE_CODE;
		endcase
	endfunction : code_of

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_sync_code <= seq_pkg::IDLE_CODE;
		end else if (link.slot_valid) begin
			o_sync_code <= code_of(link.slot_kind);
		end else begin
			o_sync_code <= seq_pkg::IDLE_CODE;
		end
	end
endmodule : sync_encoder

// ===== dv/shutter_sequencer_sync_chk.sv
// port checker for the shutter readout sequencer
`timescale 1ns/1ps
module shutter_sequencer_sync_chk (
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_bready,
	input wire logic        i_rready,
	input wire logic        o_bvalid,
	input wire logic        o_rvalid,
	input wire logic        o_pixel_reset,
	input wire logic        o_pixel_sample,
	input wire logic        o_integrating,
	input wire logic [9:0]  o_data [seq_pkg::DATA_CHANNELS],
	input wire logic [9:0]  o_sync_code
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	a_code_set: assert property (o_sync_code inside {10'h000, 10'h059, 10'h056,
		10'h05A, 10'h055, 10'h0A9, 10'h0A6, 10'h13C, 10'h193}) else $error("bad sync code");
	a_idle_quiet: assert property (o_sync_code == 10'h000 |->
		o_data[0] == 10'h000 && o_data[11] == 10'h000) else $error("data without code");
	a_sample_pulse: assert property (o_pixel_sample |=> !o_pixel_sample)
		else $error("sample pulse too long");
	a_sample_fot: assert property (o_pixel_sample |=> (o_sync_code == 10'h000)[*2])
		else $error("readout without overhead");
	a_line_gap: assert property (o_sync_code == 10'h055 |=> o_sync_code == 10'h000)
		else $error("no row overhead after line");
	a_reset_integ: assert property (o_pixel_reset |-> !o_integrating)
		else $error("integrating in reset");
	a_bresp_once: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("bvalid held");
	a_rdata_once: assert property (o_rvalid && i_rready |=> !o_rvalid) else $error("rvalid held");
endmodule : shutter_sequencer_sync_chk
bind shutter_sequencer_sync shutter_sequencer_sync_chk i_chk (.i_mclk, .i_nrst, .i_bready,
	.i_rready, .o_bvalid, .o_rvalid, .o_pixel_reset, .o_pixel_sample, .o_integrating,
	.o_data, .o_sync_code);

// ===== dv/sync_rx_model.sv
// receiver model counting frame codes on the sync channel
`timescale 1ns/1ps
module sync_rx_model (
	input  wire logic       i_mclk,
	input  wire logic [9:0] i_sync,
	output int              o_fbeg = 0,
	output int              o_ffin = 0,
	output int              o_fpn = 0
);
	// counts never clear, so the bench compares running totals
	always @(posedge i_mclk) begin
		if (i_sync == 10'h059) o_fbeg <= o_fbeg + 1;
		if (i_sync == 10'h05A) o_ffin <= o_ffin + 1;
		if (i_sync == 10'h13C) o_fpn <= o_fpn + 1;
	end
endmodule : sync_rx_model

// ===== dv/tb_shutter_sequencer_sync.sv
// testbench for the shutter readout sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_shutter_sequencer_sync;
	logic        i_mclk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic        i_first_integration_input, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic        o_pixel_reset, o_pixel_sample, o_integrating;
	logic [7:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp;
	logic [9:0]  i_adc_even [seq_pkg::DATA_CHANNELS], i_adc_odd [seq_pkg::DATA_CHANNELS];
	logic [9:0]  o_data [seq_pkg::DATA_CHANNELS], o_sync_code;
	int          err_total, comparisons, fbeg, ffin, fixed_pattern_values, n, c;
	logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
	logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h400, 32'h9, 32'h13B, 32'h400,
		32'h36, 32'h1};
	shutter_sequencer_sync i_dut (.*);
	sync_rx_model i_rx (.i_mclk(i_mclk), .i_sync(o_sync_code), .o_fbeg(fbeg), .o_ffin(ffin),
		.o_fpn(fixed_pattern_values));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task conclude();
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	task lim(input bit bad);
		if (bad) begin
			err_total++;
			conclude();
		end
	endtask : lim
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int k;
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= d;
		{i_awvalid, i_wvalid, i_bready} <= 3'h7;
		tb = 1'b0;
		for (k = 0; k < 50 && !tb; k++) begin
			@(negedge i_mclk);
			{ta, tw, tb} = {o_awready, o_wready, o_bvalid};
			@(posedge i_mclk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			if (tb) i_bready <= 1'b0;
		end
		lim(k >= 50);
		`CHK("bresp", 2'b00, o_bresp)
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic ta, tr;
		logic [31:0] d;
		int k;
		@(posedge i_mclk);
		i_araddr <= a;
		{i_arvalid, i_rready} <= 2'h3;
		tr = 1'b0;
		for (k = 0; k < 50 && !tr; k++) begin
			@(negedge i_mclk);
			{ta, tr, d} = {o_arready, o_rvalid, o_rdata};
			@(posedge i_mclk);
			if (ta) i_arvalid <= 1'b0;
			if (tr) i_rready <= 1'b0;
		end
		lim(k >= 50);
		`CHK("rdata", e, d)
		`CHK("rresp", 2'b00, o_rresp)
	endtask : rd
	task frm(input int t);
		for (c = 0; c < 3000 && ffin != t; c++) @(negedge i_mclk);
		lim(c >= 3000);
	endtask : frm
	initial begin
		{i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_wdata, i_first_integration_input} = '0;
		i_wstrb = 4'hF;
		for (n = 0; n < seq_pkg::DATA_CHANNELS; n++) begin
			i_adc_even[n] = 10'(n + 1);
			i_adc_odd[n]  = 10'(n + 32);
		end
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1'b1;
		for (n = 0; n < 10; n++) rd(ra[n], rv[n]);
		rd(8'h3C, 32'h0);
		wr(8'h14, 32'h1);
		wr(8'h18, 32'h2);
		wr(8'h1C, 32'h2);
		wr(8'h20, 32'h2);
		wr(8'h00, 32'h7);
		repeat (5) @(negedge i_mclk);
		`CHK("pixel_reset", 1'b1, o_pixel_reset)
		@(posedge i_mclk) i_first_integration_input <= 1'b1;
		repeat (6) @(negedge i_mclk);
		`CHK("integrating", 1'b1, o_integrating)
		`CHK("pixel_reset", 1'b0, o_pixel_reset)
		@(posedge i_mclk) i_first_integration_input <= 1'b0;
		frm(1);
		`CHK("frame begins", 1, fbeg)
		`CHK("stored pattern words", 4, fixed_pattern_values)
		repeat (200) @(negedge i_mclk);
		`CHK("frame ends", 1, ffin)
		`CHK("pixel_reset", 1'b1, o_pixel_reset)
		wr(8'h04, 32'h40);
		wr(8'h08, 32'h1);
		wr(8'h10, 32'h4);
		wr(8'h00, 32'h5);
		@(posedge i_mclk) i_first_integration_input <= 1'b1;
		@(posedge i_mclk) i_first_integration_input <= 1'b0;
		for (n = 0; n < 50 && o_integrating !== 1'b1; n++) @(negedge i_mclk);
		lim(n >= 50);
		for (c = 0; c < 50 && o_integrating === 1'b1; c++) @(negedge i_mclk);
		`CHK("integration cycles", 8, c)
		frm(2);
		`CHK("frame begins", 2, fbeg)
		// pipelined master: reset length 16 plus integration 4 exceeds the 3 lines read
		wr(8'h00, 32'h1);
		frm(4);
		`CHK("frame begins", 4, fbeg)
		`CHK("stored pattern words", 16, fixed_pattern_values)
		conclude();
	end
endmodule : tb_shutter_sequencer_sync
